// ==== pkg/loop_ctrl_pkg.sv ====
// Constants and types shared by the first-loop control register logic
package loop_ctrl_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] ADDR_LOOP_CONTROL_FIRST  = 8'h1d;
  localparam logic [7:0] ADDR_LOOP_CONTROL_SECOND = 8'h1e;
  localparam logic [7:0] ADDR_LOOP_MODE_SELECT    = 8'h1f;
  localparam logic [7:0] ADDR_REFERENCE_SELECT    = 8'h20;

  // Field positions, first control register
  localparam int HITLESS_BIT   = 0;
  localparam int BW_LSB        = 1;
  localparam int SLOPE_LSB     = 4;
  localparam int HS_BW_LSB     = 6;
  // Field positions, second control register
  localparam int REVERT_BIT    = 0;
  localparam int RSVD_LSB      = 1;
  localparam int UPDATE_LSB    = 4;
  localparam int POST_FILT_LSB = 6;
  // Field positions, mode and reference-select registers
  localparam int MODE_LSB      = 0;
  localparam int REFSEL_LSB    = 0;

  // Field values after reset
  localparam logic [1:0] SLOPE_RESET      = 2'h3;  // Unlimited
  localparam logic [1:0] HS_BW_RESET      = 2'h1;  // 1.0 MHz
  localparam logic [2:0] BW_RESET_MASTER  = 3'h6;  // Fast lock
  localparam logic [2:0] BW_RESET_SLAVE   = 3'h5;  // 890 Hz
  localparam logic [2:0] BW_HIGH_STAB     = 3'h7;  // Takes bandwidth from bits 7:6
  localparam logic       REVERT_RESET     = 1'b0;
  localparam logic [2:0] RSVD_RESET       = 3'h2;
  localparam logic [1:0] UPDATE_RESET     = 2'h0;  // 26 ms
  localparam logic [1:0] POST_FILT_MASTER = 2'h0;  // Bypass
  localparam logic [1:0] POST_FILT_SLAVE  = 2'h1;  // 18 mHz
  localparam logic [1:0] MODE_RESET       = 2'h0;  // Until straps are caught
  localparam logic [3:0] REFSEL_RESET     = 4'h0;

  // Operating modes of the mode field
  typedef enum logic [1:0] {
    MODE_MANUAL_NORMAL   = 2'h0,
    MODE_MANUAL_HOLDOVER = 2'h1,
    MODE_MANUAL_FREERUN  = 2'h2,
    MODE_AUTO_NORMAL     = 2'h3
  } loop_mode_t;

  // Loop condition reported to the datapath
  typedef enum logic [1:0] {
    LOOP_FREERUN  = 2'h0,
    LOOP_NORMAL   = 2'h1,
    LOOP_HOLDOVER = 2'h2
  } loop_state_t;

  // Holdover refresh timing: a 1 ms tick and intervals counted in ticks
  localparam int  TICK_PERIOD_NS = 1000000;
  localparam int  CLK_PERIOD_NS  = 8;
  localparam int  TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int  TICK_CNT_W     = 17;
  localparam int  IVL_CNT_W      = 16;
  localparam logic [15:0] IVL_26MS_TICKS = 16'd26;
  localparam logic [15:0] IVL_1S_TICKS   = 16'd1000;
  localparam logic [15:0] IVL_10S_TICKS  = 16'd10000;
  localparam logic [15:0] IVL_60S_TICKS  = 16'd60000;

  // Edges after reset release before straps are loaded
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage : loop_ctrl_pkg

// ==== pkg/loop_cfg_if.sv ====
// Carrier between the register bank and the loop mode controller
`timescale 1ns/1ps
interface loop_cfg_if;
  import loop_ctrl_pkg::*;

  loop_mode_t  mode;
  logic [3:0]  manual_ref;
  logic        revert_en;
  logic [1:0]  update_sel;
  loop_state_t state;
  logic [3:0]  active_ref;
  logic        refresh;

  modport regs (output mode, manual_ref, revert_en, update_sel,
                input  state, active_ref, refresh);
  modport ctrl (input  mode, manual_ref, revert_en, update_sel,
                output state, active_ref, refresh);
endinterface : loop_cfg_if

// ==== rtl/loop_mode_ctrl.sv ====
// Loop mode state machine, reference choice and holdover refresh timer
`timescale 1ns/1ps
module loop_mode_ctrl
  import loop_ctrl_pkg::*;
#(
  parameter int NUM_REFS    = 9,
  parameter int TICK_CYCLES = loop_ctrl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // Reference qualification, synchronised
  input  wire logic [NUM_REFS-1:0] i_ref_ok,
  // Configuration and status
  loop_cfg_if.ctrl                 cfg
);

  loop_state_t           state_q;
  logic [3:0]            active_q;
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic [IVL_CNT_W-1:0]  ivl_cnt_q;
  logic                  refresh_q;
  logic                  tick;
  logic [IVL_CNT_W-1:0]  ivl_len;
  logic [3:0]            best;
  logic                  any_ok;
  logic                  manual_ok;
  logic                  active_ok;

  // Lowest index wins among qualified references
  always_comb begin
    best   = 4'h0;
    any_ok = 1'b0;
    for (int i = NUM_REFS - 1; i >= 0; i--) begin
      if (i_ref_ok[i]) begin
        best   = 4'(i);
        any_ok = 1'b1;
      end
    end
  end

  assign manual_ok = (32'(cfg.manual_ref) < NUM_REFS) && i_ref_ok[cfg.manual_ref];
  assign active_ok = (32'(active_q) < NUM_REFS) && i_ref_ok[active_q];

  // Loop state follows the mode field on the next clock edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= LOOP_FREERUN;
    end else begin
      unique case (cfg.mode)
        MODE_MANUAL_NORMAL:   state_q <= manual_ok ? LOOP_NORMAL :
                                         (state_q == LOOP_FREERUN ? LOOP_FREERUN
                                                                  : LOOP_HOLDOVER);
        MODE_MANUAL_HOLDOVER: state_q <= LOOP_HOLDOVER;
        MODE_MANUAL_FREERUN:  state_q <= LOOP_FREERUN;
        MODE_AUTO_NORMAL:     state_q <= any_ok ? LOOP_NORMAL :
                                         (state_q == LOOP_FREERUN ? LOOP_FREERUN
                                                                  : LOOP_HOLDOVER);
      endcase
    end
  end

  // Active reference: manual choice, or automatic switching
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_q <= REFSEL_RESET;
    end else if (cfg.mode == MODE_MANUAL_NORMAL) begin
      active_q <= cfg.manual_ref;
    end else if (cfg.mode == MODE_AUTO_NORMAL && any_ok) begin
      if (!active_ok || cfg.revert_en) begin
        active_q <= best;
      end
    end
  end

  // Millisecond tick divider
  assign tick = (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1));
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // Interval length in ticks
  always_comb begin
    unique case (cfg.update_sel)
      2'h0:    ivl_len = IVL_26MS_TICKS;
      2'h1:    ivl_len = IVL_1S_TICKS;
      2'h2:    ivl_len = IVL_10S_TICKS;
      default: ivl_len = IVL_60S_TICKS;
    endcase
  end

  // Holdover value refresh only while locked
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ivl_cnt_q <= '0;
      refresh_q <= 1'b0;
    end else if (state_q != LOOP_NORMAL) begin
      ivl_cnt_q <= '0;
      refresh_q <= 1'b0;
    end else if (tick) begin
      refresh_q <= (ivl_cnt_q >= ivl_len - 1'b1);
      ivl_cnt_q <= (ivl_cnt_q >= ivl_len - 1'b1) ? '0 : ivl_cnt_q + 1'b1;
    end else begin
      refresh_q <= 1'b0;
    end
  end

  assign cfg.state      = state_q;
  assign cfg.active_ref = active_q;
  assign cfg.refresh    = refresh_q;

endmodule : loop_mode_ctrl

// ==== rtl/first_loop_ctrl_regs.sv ====
// Control and mode register bank for the first loop
//
// Summary of operation
// - Slope limit bits 5:4, reset unlimited
// - High-stability bandwidth bits 7:6, reset 1.0 MHz
// - High-stability bandwidth used only when bandwidth 111
// - Revertive switching enable, reset non-revertive
// - Holdover update interval 26 ms to 60 s
// - Holdover post-filter bypass, 18 mHz, 0.6, 10 Hz
// - Post-filter reset follows slave-enable pin
// - Manual normal tracks reference-select register
// - Manual normal enters holdover on reference failure
// - Manual holdover stays in holdover
// - Manual free-run stays in free-run
// - Automatic normal locks best qualified reference
// - Active failure switches to lowest-index qualified
// - No qualified reference means holdover, except from free-run
// - Mode reset value from mode strap pins
// - Bandwidth code 111 selects high-stability bandwidth
// - Reference select: read in auto, write manual
`timescale 1ns/1ps
module first_loop_ctrl_regs
  import loop_ctrl_pkg::*;
#(
  parameter int NUM_REFS    = 9,
  parameter int TICK_CYCLES = loop_ctrl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // Register port behind the serial interface
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  input  wire logic [7:0]          i_reg_wdata,
  output      logic [7:0]          o_reg_rdata,
  // Strap pins
  input  wire logic                i_slave_en,
  input  wire logic                i_hitless_pin,
  input  wire logic [1:0]          i_mode_strap_pins,
  // Reference monitor results
  input  wire logic [NUM_REFS-1:0] i_ref_qualified,
  // Loop configuration outputs
  output      logic                o_phase_realign,
  output      logic [2:0]          o_loop_bw_sel,
  output      logic                o_high_stability_en,
  output      logic [1:0]          o_high_stability_bw,
  output      logic [1:0]          o_phase_slope_limit,
  output      logic                o_revert_en,
  output      logic [1:0]          o_holdover_update,
  output      logic [1:0]          o_holdover_post_filter,
  // Loop status outputs
  output      logic [1:0]          o_loop_mode,
  output      logic [1:0]          o_loop_state,
  output      logic                o_auto_switch_en,
  output      logic [3:0]          o_active_ref,
  output      logic                o_holdover_refresh
);

  loop_cfg_if cfg ();

  logic [3:0]          strap_s1_q;
  logic [3:0]          strap_s2_q;
  logic [NUM_REFS-1:0] ref_s1_q;
  logic [NUM_REFS-1:0] ref_s2_q;
  logic [1:0]          settle_q;
  logic                strap_load;
  logic [7:0]          ctrl_first_q;
  logic [7:0]          ctrl_second_q;
  logic [1:0]          mode_q;
  logic [3:0]          refsel_q;
  logic [7:0]          rdata_q;
  logic                wr_first;
  logic                wr_second;
  logic                wr_mode;
  logic                wr_refsel;
  logic                slave_s;
  logic                hitless_s;
  logic [1:0]          mode_pins_s;

  // Two-stage synchronisers for pins and monitor inputs
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
      ref_s1_q   <= '0;
      ref_s2_q   <= '0;
    end else begin
      strap_s1_q <= {i_mode_strap_pins, i_hitless_pin, i_slave_en};
      strap_s2_q <= strap_s1_q;
      ref_s1_q   <= i_ref_qualified;
      ref_s2_q   <= ref_s1_q;
    end
  end

  assign slave_s     = strap_s2_q[0];
  assign hitless_s   = strap_s2_q[1];
  assign mode_pins_s = strap_s2_q[3:2];

  // One-shot strap load once the synchronisers have settled
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_q <= 2'h0;
    end else if (settle_q != STRAP_SETTLE + 2'h1) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  assign strap_load = (settle_q == STRAP_SETTLE);

  // Address decode of write strobes
  assign wr_first  = i_reg_wr && (i_reg_addr == ADDR_LOOP_CONTROL_FIRST);
  assign wr_second = i_reg_wr && (i_reg_addr == ADDR_LOOP_CONTROL_SECOND);
  assign wr_mode   = i_reg_wr && (i_reg_addr == ADDR_LOOP_MODE_SELECT);
  assign wr_refsel = i_reg_wr && (i_reg_addr == ADDR_REFERENCE_SELECT);

  // First control register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_first_q[HITLESS_BIT]             <= 1'b1;
      ctrl_first_q[BW_LSB+:3]               <= BW_RESET_MASTER;
      ctrl_first_q[SLOPE_LSB+:2]            <= SLOPE_RESET;
      ctrl_first_q[HS_BW_LSB+:2]            <= HS_BW_RESET;
    end else if (strap_load) begin
      ctrl_first_q[HITLESS_BIT] <= !(hitless_s && !slave_s);
      ctrl_first_q[BW_LSB+:3]   <= slave_s ? BW_RESET_SLAVE : BW_RESET_MASTER;
    end else if (wr_first) begin
      ctrl_first_q <= i_reg_wdata;
    end
  end

  // Second control register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_second_q[REVERT_BIT]      <= REVERT_RESET;
      ctrl_second_q[RSVD_LSB+:3]     <= RSVD_RESET;
      ctrl_second_q[UPDATE_LSB+:2]   <= UPDATE_RESET;
      ctrl_second_q[POST_FILT_LSB+:2] <= POST_FILT_MASTER;
    end else if (strap_load) begin
      ctrl_second_q[POST_FILT_LSB+:2] <= slave_s ? POST_FILT_SLAVE
                                                 : POST_FILT_MASTER;
    end else if (wr_second) begin
      ctrl_second_q <= i_reg_wdata;
    end
  end

  // Mode register, upper bits not stored
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= MODE_RESET;
    end else if (strap_load) begin
      mode_q <= mode_pins_s;
    end else if (wr_mode) begin
      mode_q <= i_reg_wdata[MODE_LSB+:2];
    end
  end

  // Reference select, writable only in manual normal mode
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refsel_q <= REFSEL_RESET;
    end else if (wr_refsel && mode_q == MODE_MANUAL_NORMAL) begin
      refsel_q <= i_reg_wdata[REFSEL_LSB+:4];
    end
  end

  // Read data registered on a read strobe, unmapped reads zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_LOOP_CONTROL_FIRST:  rdata_q <= ctrl_first_q;
        ADDR_LOOP_CONTROL_SECOND: rdata_q <= ctrl_second_q;
        ADDR_LOOP_MODE_SELECT:    rdata_q <= {6'h00, mode_q};
        ADDR_REFERENCE_SELECT:    rdata_q <= {4'h0, cfg.active_ref};
        default:                  rdata_q <= 8'h00;
      endcase
    end
  end
  assign o_reg_rdata = rdata_q;

  // Configuration to the mode controller
  assign cfg.mode       = loop_mode_t'(mode_q);
  assign cfg.manual_ref = refsel_q;
  assign cfg.revert_en  = ctrl_second_q[REVERT_BIT];
  assign cfg.update_sel = ctrl_second_q[UPDATE_LSB+:2];

  loop_mode_ctrl #(
    .NUM_REFS    (NUM_REFS),
    .TICK_CYCLES (TICK_CYCLES)
  ) u_mode_ctrl (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ref_ok  (ref_s2_q),
    .cfg       (cfg.ctrl)
  );

  // Loop configuration outputs
  assign o_phase_realign        = ctrl_first_q[HITLESS_BIT];
  assign o_loop_bw_sel          = ctrl_first_q[BW_LSB+:3];
  assign o_high_stability_en    = (ctrl_first_q[BW_LSB+:3] == BW_HIGH_STAB);
  assign o_high_stability_bw    = ctrl_first_q[HS_BW_LSB+:2];
  assign o_phase_slope_limit    = ctrl_first_q[SLOPE_LSB+:2];
  assign o_revert_en            = ctrl_second_q[REVERT_BIT];
  assign o_holdover_update      = ctrl_second_q[UPDATE_LSB+:2];
  assign o_holdover_post_filter = ctrl_second_q[POST_FILT_LSB+:2];

  // Loop status outputs
  assign o_loop_mode        = mode_q;
  assign o_loop_state       = cfg.state;
  assign o_auto_switch_en   = (mode_q == MODE_AUTO_NORMAL);
  assign o_active_ref       = cfg.active_ref;
  assign o_holdover_refresh = cfg.refresh;

endmodule : first_loop_ctrl_regs

// ==== sim/first_loop_ctrl_regs_chk.sv ====
// Concurrent checks on the first-loop register bank ports
`timescale 1ns/1ps
module first_loop_ctrl_regs_chk
  import loop_ctrl_pkg::*;
#(
  parameter int NUM_REFS    = 9,
  parameter int TICK_CYCLES = loop_ctrl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  // Configuration and status outputs
  input wire logic [2:0] o_loop_bw_sel,
  input wire logic       o_high_stability_en,
  input wire logic [1:0] o_high_stability_bw,
  input wire logic [1:0] o_phase_slope_limit,
  input wire logic       o_revert_en,
  input wire logic [1:0] o_holdover_update,
  input wire logic [1:0] o_holdover_post_filter,
  input wire logic [1:0] o_loop_mode,
  input wire logic [1:0] o_loop_state,
  input wire logic       o_auto_switch_en,
  input wire logic       o_holdover_refresh
);
  logic [7:0] wd_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Write data of the previous edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_q <= 8'h00;
    end else begin
      wd_q <= i_reg_wdata;
    end
  end

  property p_slope_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL_FIRST |=> o_phase_slope_limit == wd_q[5:4];
  endproperty
  a_slope_wr: assert property (p_slope_wr) else $error("slope field not written");
  property p_hs_bw_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL_FIRST |=> o_high_stability_bw == wd_q[7:6];
  endproperty
  a_hs_bw_wr: assert property (p_hs_bw_wr) else $error("hs bandwidth not written");
  property p_hs_en;
    o_high_stability_en == (o_loop_bw_sel == BW_HIGH_STAB);
  endproperty
  a_hs_en: assert property (p_hs_en) else $error("hs enable decode wrong");
  property p_revert_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL_SECOND |=> o_revert_en == wd_q[0];
  endproperty
  a_revert_wr: assert property (p_revert_wr) else $error("revert bit not written");
  property p_update_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL_SECOND |=> o_holdover_update == wd_q[5:4];
  endproperty
  a_update_wr: assert property (p_update_wr) else $error("update field not written");
  property p_post_filt_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_CONTROL_SECOND |=> o_holdover_post_filter == wd_q[7:6];
  endproperty
  a_post_filt_wr: assert property (p_post_filt_wr) else $error("post filter not written");
  property p_mode_wr;
    i_reg_wr && i_reg_addr == ADDR_LOOP_MODE_SELECT |=> o_loop_mode == wd_q[1:0];
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write not immediate");
  property p_auto_sw;
    o_auto_switch_en == (o_loop_mode == 2'h3);
  endproperty
  a_auto_sw: assert property (p_auto_sw) else $error("auto switch decode wrong");
  property p_hold_mode;
    (o_loop_mode == 2'h1) [*2] |-> o_loop_state == LOOP_HOLDOVER;
  endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("manual holdover left");
  property p_free_mode;
    (o_loop_mode == 2'h2) [*2] |-> o_loop_state == LOOP_FREERUN;
  endproperty
  a_free_mode: assert property (p_free_mode) else $error("manual free-run left");
  property p_refresh;
    o_holdover_refresh |-> $past(o_loop_state) == LOOP_NORMAL ##1 !o_holdover_refresh;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh outside normal");
endmodule : first_loop_ctrl_regs_chk

// ==== sim/tb_first_loop_ctrl_regs.sv ====
// Self-checking bench for the first-loop control register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_first_loop_ctrl_regs;
  import loop_ctrl_pkg::*;
  // Bench signals
  logic       ref_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, slave_en = 1'b0, hitless_pin = 1'b0;
  logic [1:0] mode_strap_pins = 2'h0;
  logic [8:0] ref_qualified = 9'h000;
  logic       phase_realign, high_stability_en, revert_en, auto_switch_en, holdover_refresh;
  logic [2:0] loop_bw_sel;
  logic [1:0] high_stability_bw, phase_slope_limit, holdover_update, holdover_post_filter;
  logic [1:0] loop_mode, loop_state;
  logic [3:0] active_ref;
  int         mismatches = 0, comparisons = 0, n, k;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;

  first_loop_ctrl_regs #(.NUM_REFS(9), .TICK_CYCLES(4)) u_first_loop_ctrl_regs (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_slave_en(slave_en), .i_hitless_pin(hitless_pin), .i_mode_strap_pins(mode_strap_pins),
    .i_ref_qualified(ref_qualified), .o_phase_realign(phase_realign),
    .o_loop_bw_sel(loop_bw_sel), .o_high_stability_en(high_stability_en),
    .o_high_stability_bw(high_stability_bw), .o_phase_slope_limit(phase_slope_limit),
    .o_revert_en(revert_en), .o_holdover_update(holdover_update),
    .o_holdover_post_filter(holdover_post_filter), .o_loop_mode(loop_mode),
    .o_loop_state(loop_state), .o_auto_switch_en(auto_switch_en),
    .o_active_ref(active_ref), .o_holdover_refresh(holdover_refresh));

  // Verdict and end of run
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr

  // One-cycle register read and compare
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    `CHK(s, e, reg_rdata)
  endtask : rd

  // Reset with the given strap levels
  task automatic do_reset(input logic s, input logic h, input logic [1:0] m);
    @(negedge ref_clk);
    rst_n = 1'b0;
    slave_en = s;
    hitless_pin = h;
    mode_strap_pins = m;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
  endtask : do_reset

  // Cycles until the next refresh pulse, bounded
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (holdover_refresh !== 1'b1 && c <= 5000);
    if (c > 5000) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_pulse

  task automatic settle;
    repeat (5) @(negedge ref_clk);
  endtask : settle

  // Main sequence
  initial begin
    do_reset(1'b0, 1'b1, 2'h2);
    rd(ADDR_LOOP_CONTROL_FIRST, 8'h7c, "ctl1 reset");
    rd(ADDR_LOOP_CONTROL_SECOND, 8'h04, "ctl2 reset");
    rd(ADDR_LOOP_MODE_SELECT, 8'h02, "mode reset");
    `CHK("free state", LOOP_FREERUN, loop_state)
    `CHK("realign master", 1'b0, phase_realign)
    `CHK("bw master", 3'h6, loop_bw_sel)
    rd(8'h21, 8'h00, "unmapped");
    // Slope and bandwidth codes, with and without code 111
    for (int i = 0; i < 8; i++) begin
      d = {2'(i % 3), 2'(i), (i > 3) ? 3'h7 : 3'h6, 1'b1};
      wr(ADDR_LOOP_CONTROL_FIRST, d);
      `CHK("slope", d[5:4], phase_slope_limit)
      `CHK("hs bw", d[7:6], high_stability_bw)
      `CHK("hs en", (i > 3), high_stability_en)
      rd(ADDR_LOOP_CONTROL_FIRST, d, "ctl1 back");
    end
    // Holdover interval and post-filter codes
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 2'(i), 3'h2, 1'(i)};
      wr(ADDR_LOOP_CONTROL_SECOND, d);
      `CHK("revert", d[0], revert_en)
      `CHK("update", d[5:4], holdover_update)
      `CHK("post filter", d[7:6], holdover_post_filter)
    end
    wr(ADDR_LOOP_CONTROL_SECOND, 8'h04);
    // Manual normal tracks the selected reference
    ref_qualified = 9'h00e;
    wr(ADDR_LOOP_MODE_SELECT, 8'h00);
    wr(ADDR_REFERENCE_SELECT, 8'h03);
    settle();
    `CHK("manual ref", 4'h3, active_ref)
    `CHK("manual normal", LOOP_NORMAL, loop_state)
    `CHK("manual no auto", 1'b0, auto_switch_en)
    rd(ADDR_REFERENCE_SELECT, 8'h03, "refsel manual");
    wait_pulse(n);
    wait_pulse(n);
    `CHK("refresh gap", 26 * 4, n)
    wr(ADDR_LOOP_CONTROL_SECOND, 8'h14);
    wait_pulse(n);
    wait_pulse(n);
    `CHK("refresh gap 1 s", 1000 * 4, n)
    ref_qualified = 9'h006;
    settle();
    `CHK("manual fail", LOOP_HOLDOVER, loop_state)
    k = 0;
    repeat (250) begin
      @(negedge ref_clk);
      if (holdover_refresh === 1'b1) k++;
    end
    `CHK("refresh held", 0, k)
    // Automatic normal: priority, switchover, no reference
    wr(ADDR_LOOP_MODE_SELECT, 8'h03);
    `CHK("auto mode", 2'h3, loop_mode)
    settle();
    `CHK("auto sw", 1'b1, auto_switch_en)
    `CHK("auto ref", 4'h1, active_ref)
    `CHK("auto normal", LOOP_NORMAL, loop_state)
    ref_qualified = 9'h004;
    settle();
    `CHK("switchover", 4'h2, active_ref)
    wr(ADDR_REFERENCE_SELECT, 8'h05);
    rd(ADDR_REFERENCE_SELECT, 8'h02, "refsel auto");
    ref_qualified = 9'h000;
    settle();
    `CHK("no ref", LOOP_HOLDOVER, loop_state)
    // Manual holdover and free-run ignore good references
    ref_qualified = 9'h1ff;
    wr(ADDR_LOOP_MODE_SELECT, 8'h01);
    settle();
    `CHK("manual hold", LOOP_HOLDOVER, loop_state)
    wr(ADDR_LOOP_MODE_SELECT, 8'h02);
    settle();
    `CHK("manual free", LOOP_FREERUN, loop_state)
    // Slave-side straps
    ref_qualified = 9'h000;
    do_reset(1'b1, 1'b1, 2'h1);
    rd(ADDR_LOOP_CONTROL_FIRST, 8'h7b, "ctl1 slave");
    rd(ADDR_LOOP_CONTROL_SECOND, 8'h44, "ctl2 slave");
    rd(ADDR_LOOP_MODE_SELECT, 8'h01, "mode slave");
    `CHK("strap hold", LOOP_HOLDOVER, loop_state)
    `CHK("realign slave", 1'b1, phase_realign)
    `CHK("bw slave", 3'h5, loop_bw_sel)
    complete_run();
  end
endmodule : tb_first_loop_ctrl_regs

bind first_loop_ctrl_regs first_loop_ctrl_regs_chk #(.NUM_REFS(NUM_REFS),
  .TICK_CYCLES(TICK_CYCLES)) u_first_loop_ctrl_regs_chk (.i_ref_clk, .i_rst_n, .i_reg_addr,
  .i_reg_wr, .i_reg_wdata, .o_loop_bw_sel, .o_high_stability_en, .o_high_stability_bw,
  .o_phase_slope_limit, .o_revert_en, .o_holdover_update, .o_holdover_post_filter,
  .o_loop_mode, .o_loop_state, .o_auto_switch_en, .o_holdover_refresh);
